// ---- logic/rtcsa_top.sv ----
// Clock block top: APB register file, shadow time, alarm and countdown.
// Assumes an APB3 master on mclk; registers sit at four times the index.
`timescale 1ns/1ps
module rtcsa_top #(
    parameter int SLOW_DIV = rtcsa_pkg::SLOW_DIV_CYC,
    parameter int SUB_DIV = rtcsa_pkg::SUB_DIV_CYC
) (
    input wire logic mclk,
    input wire logic rst_b,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [15:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    output logic [6:0] osc_trim,
    output logic alarm_match
);
    // Live counters
    logic [5:0] cal_sec, cal_min;
    logic [4:0] cal_hr, cal_date;
    logic [2:0] cal_wday;
    logic [3:0] cal_mon;
    logic [7:0] cal_year;
    logic cal_fault, slow_tick, sub_tick, sec_tick, load;
    // Control state
    logic wr_q, wr_d, rd_q, rd_d, frz_q, frz_d, pend_q, pend_d;
    logic fail_q, fail_d, alarm_q, alarm_d;
    logic [6:0] trim_q, trim_d;
    logic [5:0] amin_q, amin_d;
    logic [4:0] ahr_q, ahr_d;
    // Shadow copies
    logic [5:0] sh_sec_q, sh_sec_d, sh_min_q, sh_min_d;
    logic [4:0] sh_hr_q, sh_hr_d, sh_date_q, sh_date_d;
    logic [2:0] sh_wday_q, sh_wday_d;
    logic [3:0] sh_mon_q, sh_mon_d;
    logic [7:0] sh_year_q, sh_year_d;
    // Countdown and bus
    logic [7:0] sub_q, sub_d;
    logic [31:0] rdata_q, rdata_d;
    logic [13:0] idx;
    logic wr_acc, tracking;

    // True when the address hits a mapped register word
    function automatic logic reg_hit(input logic [15:0] a);
        logic [13:0] i;
        i = a[15:2];
        return a[1:0] == 2'b00 && (i == rtcsa_pkg::IDX_TRIM
            || i == rtcsa_pkg::IDX_CTRL || i == rtcsa_pkg::IDX_SUBSEC
            || (i >= rtcsa_pkg::IDX_SEC && i <= rtcsa_pkg::IDX_YEAR)
            || i == rtcsa_pkg::IDX_AMIN || i == rtcsa_pkg::IDX_AHR);
    endfunction

    // Slow transfer tick and 1/256 s tick
    rtcsa_tick_gen #(
        .DIV(SLOW_DIV)
    ) u_slow (
        .mclk(mclk),
        .rst_b(rst_b),
        .tick(slow_tick)
    );

    rtcsa_tick_gen #(
        .DIV(SUB_DIV)
    ) u_sub (
        .mclk(mclk),
        .rst_b(rst_b),
        .tick(sub_tick)
    );

    // Shadow is loaded into the counters on the slow tick after clearing
    assign load = slow_tick && pend_q;
    assign sec_tick = sub_tick && sub_q == 8'h00 && !load;

    rtcsa_calendar u_cal (
        .mclk(mclk),
        .rst_b(rst_b),
        .sec_tick(sec_tick),
        .load(load),
        .ld_sec(sh_sec_q),
        .ld_min(sh_min_q),
        .ld_hr(sh_hr_q),
        .ld_wday(sh_wday_q),
        .ld_date(sh_date_q),
        .ld_mon(sh_mon_q),
        .ld_year(sh_year_q),
        .sec_q(cal_sec),
        .min_q(cal_min),
        .hr_q(cal_hr),
        .wday_q(cal_wday),
        .date_q(cal_date),
        .mon_q(cal_mon),
        .year_q(cal_year),
        .fault_q(cal_fault)
    );

    // Bus decode; zero wait states
    assign idx = paddr[15:2];
    assign wr_acc = psel && penable && pwrite && reg_hit(paddr);
    assign pready = 1'b1;
    assign pslverr = psel && penable && !reg_hit(paddr);
    assign prdata = rdata_q;
    assign osc_trim = trim_q;
    assign alarm_match = alarm_q;

    // Control next state: flags, freeze, transfer, trim and alarm targets
    always_comb
    begin
        {wr_d, rd_d, pend_d, fail_d} = {wr_q, rd_q, pend_q, fail_q};
        {trim_d, amin_d, ahr_d} = {trim_q, amin_q, ahr_q};
        frz_d = rd_q;
        alarm_d = cal_min == amin_q && cal_hr == ahr_q;
        if (load)
            pend_d = 1'b0;
        if (wr_acc && idx == rtcsa_pkg::IDX_CTRL)
        begin
            wr_d = pwdata[rtcsa_pkg::CTRL_WR_BIT];
            rd_d = pwdata[rtcsa_pkg::CTRL_RD_BIT];
            if (wr_q && !pwdata[rtcsa_pkg::CTRL_WR_BIT])
                pend_d = 1'b1;
            if (!pwdata[rtcsa_pkg::CTRL_FAIL_BIT])
                fail_d = 1'b0;
        end
        if (wr_acc && idx == rtcsa_pkg::IDX_TRIM)
            trim_d = pwdata[6:0];
        if (wr_acc && idx == rtcsa_pkg::IDX_AMIN)
            amin_d = pwdata[5:0];
        if (wr_acc && idx == rtcsa_pkg::IDX_AHR)
            ahr_d = pwdata[4:0];
        if (cal_fault)
            fail_d = 1'b1;
    end

    always_ff @(posedge mclk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            {wr_q, rd_q, frz_q, pend_q, fail_q, alarm_q} <= '0;
            trim_q <= rtcsa_pkg::TRIM_RST;
            amin_q <= 6'h00;
            ahr_q <= 5'h00;
        end
        else
        begin
            {wr_q, rd_q, frz_q, pend_q} <= {wr_d, rd_d, frz_d, pend_d};
            {fail_q, alarm_q} <= {fail_d, alarm_d};
            {trim_q, amin_q, ahr_q} <= {trim_d, amin_d, ahr_d};
        end
    end

    // Shadow follows the counters unless frozen or being written
    assign tracking = !frz_q && !rd_q && !wr_q && !pend_q;
    always_comb
    begin
        {sh_sec_d, sh_min_d, sh_hr_d} = {sh_sec_q, sh_min_q, sh_hr_q};
        {sh_wday_d, sh_date_d} = {sh_wday_q, sh_date_q};
        {sh_mon_d, sh_year_d} = {sh_mon_q, sh_year_q};
        if (tracking)
        begin
            {sh_sec_d, sh_min_d, sh_hr_d} = {cal_sec, cal_min, cal_hr};
            {sh_wday_d, sh_date_d} = {cal_wday, cal_date};
            {sh_mon_d, sh_year_d} = {cal_mon, cal_year};
        end
        else if (wr_acc && wr_q)
        begin
            unique case (idx)
                rtcsa_pkg::IDX_SEC: sh_sec_d = pwdata[5:0];
                rtcsa_pkg::IDX_MIN: sh_min_d = pwdata[5:0];
                rtcsa_pkg::IDX_HR: sh_hr_d = pwdata[4:0];
                rtcsa_pkg::IDX_WDAY: sh_wday_d = pwdata[2:0];
                rtcsa_pkg::IDX_DATE: sh_date_d = pwdata[4:0];
                rtcsa_pkg::IDX_MON: sh_mon_d = pwdata[3:0];
                rtcsa_pkg::IDX_YEAR: sh_year_d = pwdata[7:0];
                default: sh_sec_d = sh_sec_q;
            endcase
        end
    end

    always_ff @(posedge mclk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            {sh_sec_q, sh_min_q, sh_hr_q} <= '0;
            sh_wday_q <= rtcsa_pkg::WDAY_FIRST;
            sh_date_q <= rtcsa_pkg::DATE_FIRST;
            sh_mon_q <= rtcsa_pkg::MON_FIRST;
            sh_year_q <= 8'h00;
        end
        else
        begin
            {sh_sec_q, sh_min_q, sh_hr_q} <= {sh_sec_d, sh_min_d, sh_hr_d};
            {sh_wday_q, sh_date_q} <= {sh_wday_d, sh_date_d};
            {sh_mon_q, sh_year_q} <= {sh_mon_d, sh_year_d};
        end
    end

    // Sub-second countdown, restarted when a new time is loaded
    always_comb
    begin
        sub_d = sub_q;
        if (load)
            sub_d = rtcsa_pkg::SUB_TOP;
        else if (sub_tick)
            sub_d = sub_q - 8'h01;
    end

    always_ff @(posedge mclk or negedge rst_b)
    begin
        if (!rst_b)
            sub_q <= rtcsa_pkg::SUB_TOP;
        else
            sub_q <= sub_d;
    end

    // Read data captured in the setup cycle
    always_comb
    begin
        rdata_d = rdata_q;
        if (psel && !penable && !pwrite)
        begin
            rdata_d = 32'h00000000;
            if (paddr[1:0] == 2'b00)
            begin
                unique case (idx)
                    rtcsa_pkg::IDX_TRIM: rdata_d = 32'(trim_q);
                    rtcsa_pkg::IDX_CTRL:
                    begin
                        rdata_d[rtcsa_pkg::CTRL_WR_BIT] = wr_q || pend_q;
                        rdata_d[rtcsa_pkg::CTRL_RD_BIT] = frz_q;
                        rdata_d[rtcsa_pkg::CTRL_FAIL_BIT] = fail_q;
                        rdata_d[rtcsa_pkg::CTRL_ALARM_BIT] = alarm_q;
                    end
                    rtcsa_pkg::IDX_SUBSEC: rdata_d = 32'(sub_q);
                    rtcsa_pkg::IDX_SEC: rdata_d = 32'(sh_sec_q);
                    rtcsa_pkg::IDX_MIN: rdata_d = 32'(sh_min_q);
                    rtcsa_pkg::IDX_HR: rdata_d = 32'(sh_hr_q);
                    rtcsa_pkg::IDX_WDAY: rdata_d = 32'(sh_wday_q);
                    rtcsa_pkg::IDX_DATE: rdata_d = 32'(sh_date_q);
                    rtcsa_pkg::IDX_MON: rdata_d = 32'(sh_mon_q);
                    rtcsa_pkg::IDX_YEAR: rdata_d = 32'(sh_year_q);
                    rtcsa_pkg::IDX_AMIN: rdata_d = 32'(amin_q);
                    rtcsa_pkg::IDX_AHR: rdata_d = 32'(ahr_q);
                    default: rdata_d = 32'h00000000;
                endcase
            end
        end
    end

    always_ff @(posedge mclk or negedge rst_b)
    begin
        if (!rst_b)
            rdata_q <= 32'h00000000;
        else
            rdata_q <= rdata_d;
    end

    // Checks
    fail_set_a: assert property (
        @(posedge mclk) disable iff (!rst_b)
        cal_fault |=> fail_q)
        else $error("count fault did not set the error flag");

    fail_clear_a: assert property (
        @(posedge mclk) disable iff (!rst_b)
        (wr_acc && idx == rtcsa_pkg::IDX_CTRL
         && !pwdata[rtcsa_pkg::CTRL_FAIL_BIT] && !cal_fault) |=> !fail_q)
        else $error("writing zero did not clear the error flag");

    freeze_hold_a: assert property (
        @(posedge mclk) disable iff (!rst_b)
        (frz_q && rd_q) |=> ($stable(sh_sec_q) && $stable(sh_min_q)
                              && $stable(sh_hr_q)) || wr_q)
        else $error("shadow changed while frozen");

    rd_status_a: assert property (
        @(posedge mclk) disable iff (!rst_b)
        (psel && !penable && !pwrite && paddr[1:0] == 2'b00
         && idx == rtcsa_pkg::IDX_CTRL)
        |=> prdata[rtcsa_pkg::CTRL_RD_BIT] == $past(frz_q))
        else $error("freeze readback is not the shadow state");

    subsec_count_a: assert property (
        @(posedge mclk) disable iff (!rst_b)
        (sub_tick && !load) |=> sub_q == $past(sub_q) - 8'h01)
        else $error("sub-second countdown did not step");

    alarm_match_a: assert property (
        @(posedge mclk) disable iff (!rst_b)
        (cal_min == amin_q && cal_hr == ahr_q) |=> alarm_match)
        else $error("alarm missed a minute and hour match");

    xfer_load_a: assert property (
        @(posedge mclk) disable iff (!rst_b)
        load |=> (cal_sec == $past(sh_sec_q) && cal_year == $past(sh_year_q)
                  && !pend_q))
        else $error("shadow was not loaded on the slow tick");

    wr_busy_a: assert property (
        @(posedge mclk) disable iff (!rst_b)
        (pend_q && psel && !penable && !pwrite && paddr[1:0] == 2'b00
         && idx == rtcsa_pkg::IDX_CTRL) |=> prdata[rtcsa_pkg::CTRL_WR_BIT])
        else $error("write enable read zero before the load");
endmodule

// ---- inc/rtcsa_pkg.sv ----
// Constants, register indexes and calendar helpers for the clock block.
// Assumes a 100 MHz mclk and an APB master with 32-bit data.
// How it works
// - A counting fault sets the count-error flag; writing 0 clears it.
// - While freeze is on, the shadow time copies stop following time.
// - Reading the freeze bit returns whether the shadow is frozen.
// - A read-only countdown gives time to the next second in 1/256 s.
// - Alarm matches when minutes and hours both equal their targets.
// - Clearing write-enable loads the shadow on the next 500 Hz tick.
// - Write-enable reads one until that load has really happened.
// - Year 00 and every year divisible by 4 gives February 29 days.
package rtcsa_pkg;
    // Clock and tick rates
    localparam int CLK_HZ = 100_000_000;
    localparam int SLOW_HZ = 500;
    localparam int SUB_HZ = 256;
    localparam int SLOW_DIV_CYC = CLK_HZ / SLOW_HZ;
    localparam int SUB_DIV_CYC = CLK_HZ / SUB_HZ;
    // Register indexes; byte address is four times the index
    localparam logic [13:0] IDX_TRIM = 14'h2504;
    localparam logic [13:0] IDX_CTRL = 14'h2890;
    localparam logic [13:0] IDX_SUBSEC = 14'h2892;
    localparam logic [13:0] IDX_SEC = 14'h2893;
    localparam logic [13:0] IDX_MIN = 14'h2894;
    localparam logic [13:0] IDX_HR = 14'h2895;
    localparam logic [13:0] IDX_WDAY = 14'h2896;
    localparam logic [13:0] IDX_DATE = 14'h2897;
    localparam logic [13:0] IDX_MON = 14'h2898;
    localparam logic [13:0] IDX_YEAR = 14'h2899;
    localparam logic [13:0] IDX_AMIN = 14'h289E;
    localparam logic [13:0] IDX_AHR = 14'h289F;
    // Control register bit positions
    localparam int CTRL_WR_BIT = 7;
    localparam int CTRL_RD_BIT = 6;
    localparam int CTRL_FAIL_BIT = 4;
    localparam int CTRL_ALARM_BIT = 0;
    // Reset values
    localparam logic [6:0] TRIM_RST = 7'h40;
    localparam logic [7:0] SUB_TOP = 8'hFF;
    localparam logic [2:0] WDAY_FIRST = 3'h1;
    localparam logic [4:0] DATE_FIRST = 5'h01;
    localparam logic [3:0] MON_FIRST = 4'h1;
    // Field limits
    localparam logic [5:0] SEC_MAX = 6'h3B;
    localparam logic [5:0] MIN_MAX = 6'h3B;
    localparam logic [4:0] HR_MAX = 5'h17;
    localparam logic [2:0] WDAY_MAX = 3'h7;
    localparam logic [3:0] MON_MAX = 4'hC;
    localparam logic [7:0] YEAR_MAX = 8'h63;
    localparam logic [3:0] MON_FEB = 4'h2;
    localparam logic [4:0] DAYS_LONG = 5'h1F;
    localparam logic [4:0] DAYS_SHORT = 5'h1E;
    localparam logic [4:0] DAYS_FEB_LEAP = 5'h1D;
    localparam logic [4:0] DAYS_FEB = 5'h1C;

    // Days in a month; any year with low two bits zero is a leap year
    function automatic logic [4:0] days_in_month(input logic [3:0] mon,
                                                 input logic [7:0] year);
        if (mon == MON_FEB)
            return (year[1:0] == 2'b00) ? DAYS_FEB_LEAP : DAYS_FEB;
        else if (mon == 4'h4 || mon == 4'h6 || mon == 4'h9 || mon == 4'hB)
            return DAYS_SHORT;
        else
            return DAYS_LONG;
    endfunction
endpackage

// ---- logic/rtcsa_tick_gen.sv ----
// Divider producing a one-cycle enable pulse every DIV mclk cycles.
// Assumes DIV is at least 2 and below 2**20.
`timescale 1ns/1ps
module rtcsa_tick_gen #(
    parameter int DIV = 200000
) (
    input wire logic mclk,
    input wire logic rst_b,
    output logic tick
);
    logic [19:0] cnt_q;
    logic [19:0] cnt_d;

    // Count down and reload at zero
    always_comb
    begin
        if (cnt_q == 20'h00000)
            cnt_d = 20'(DIV - 1);
        else
            cnt_d = cnt_q - 20'h00001;
    end

    always_ff @(posedge mclk or negedge rst_b)
    begin
        if (!rst_b)
            cnt_q <= 20'h00000;
        else
            cnt_q <= cnt_d;
    end

    assign tick = (cnt_q == 20'h00000);
endmodule

// ---- logic/rtcsa_calendar.sv ----
// Live calendar counters: advance once a second, load from the shadow.
// Assumes sec_tick and load are one-cycle pulses on mclk.
`timescale 1ns/1ps
module rtcsa_calendar (
    input wire logic mclk,
    input wire logic rst_b,
    input wire logic sec_tick,
    input wire logic load,
    input wire logic [5:0] ld_sec,
    input wire logic [5:0] ld_min,
    input wire logic [4:0] ld_hr,
    input wire logic [2:0] ld_wday,
    input wire logic [4:0] ld_date,
    input wire logic [3:0] ld_mon,
    input wire logic [7:0] ld_year,
    output logic [5:0] sec_q,
    output logic [5:0] min_q,
    output logic [4:0] hr_q,
    output logic [2:0] wday_q,
    output logic [4:0] date_q,
    output logic [3:0] mon_q,
    output logic [7:0] year_q,
    output logic fault_q
);
    logic [5:0] sec_d, min_d;
    logic [4:0] hr_d, date_d, dim;
    logic [2:0] wday_d;
    logic [3:0] mon_d;
    logic [7:0] year_d;
    logic fault_d, bad;

    // Next time: load wins, else carry chain on each second
    always_comb
    begin
        {sec_d, min_d, hr_d} = {sec_q, min_q, hr_q};
        {wday_d, date_d, mon_d, year_d} = {wday_q, date_q, mon_q, year_q};
        dim = rtcsa_pkg::days_in_month(mon_q, year_q);
        bad = sec_q > rtcsa_pkg::SEC_MAX || min_q > rtcsa_pkg::MIN_MAX
            || hr_q > rtcsa_pkg::HR_MAX || wday_q == 3'h0
            || date_q == 5'h00 || date_q > dim || mon_q == 4'h0
            || mon_q > rtcsa_pkg::MON_MAX || year_q > rtcsa_pkg::YEAR_MAX;
        fault_d = sec_tick && !load && bad;
        if (load)
        begin
            {sec_d, min_d, hr_d} = {ld_sec, ld_min, ld_hr};
            {wday_d, date_d, mon_d, year_d} = {ld_wday, ld_date, ld_mon,
                                               ld_year};
        end
        else if (sec_tick)
        begin
            if (sec_q < rtcsa_pkg::SEC_MAX)
                sec_d = sec_q + 6'h01;
            else
            begin
                sec_d = 6'h00;
                if (min_q < rtcsa_pkg::MIN_MAX)
                    min_d = min_q + 6'h01;
                else
                begin
                    min_d = 6'h00;
                    if (hr_q < rtcsa_pkg::HR_MAX)
                        hr_d = hr_q + 5'h01;
                    else
                    begin
                        hr_d = 5'h00;
                        wday_d = (wday_q >= rtcsa_pkg::WDAY_MAX
                                  || wday_q == 3'h0)
                                 ? rtcsa_pkg::WDAY_FIRST : wday_q + 3'h1;
                        if (date_q < dim)
                            date_d = date_q + 5'h01;
                        else
                        begin
                            date_d = rtcsa_pkg::DATE_FIRST;
                            if (mon_q < rtcsa_pkg::MON_MAX)
                                mon_d = mon_q + 4'h1;
                            else
                            begin
                                mon_d = rtcsa_pkg::MON_FIRST;
                                year_d = (year_q < rtcsa_pkg::YEAR_MAX)
                                         ? year_q + 8'h01 : 8'h00;
                            end
                        end
                    end
                end
            end
        end
    end

    always_ff @(posedge mclk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            {sec_q, min_q, hr_q} <= '0;
            wday_q <= rtcsa_pkg::WDAY_FIRST;
            date_q <= rtcsa_pkg::DATE_FIRST;
            mon_q <= rtcsa_pkg::MON_FIRST;
            year_q <= 8'h00;
            fault_q <= 1'b0;
        end
        else
        begin
            {sec_q, min_q, hr_q} <= {sec_d, min_d, hr_d};
            {wday_q, date_q, mon_q, year_q} <= {wday_d, date_d, mon_d, year_d};
            fault_q <= fault_d;
        end
    end

    // Leap February rolls from 28 to 29 at midnight
    leap_day_a: assert property (
        @(posedge mclk) disable iff (!rst_b)
        (sec_tick && !load && mon_q == rtcsa_pkg::MON_FEB
         && date_q == rtcsa_pkg::DAYS_FEB && year_q[1:0] == 2'b00
         && sec_q == rtcsa_pkg::SEC_MAX && min_q == rtcsa_pkg::MIN_MAX
         && hr_q == rtcsa_pkg::HR_MAX)
        |=> (date_q == rtcsa_pkg::DAYS_FEB_LEAP
             && mon_q == rtcsa_pkg::MON_FEB))
        else $error("leap February did not reach day 29");

    // Seconds wrap at 59 and carry into minutes
    sec_wrap_a: assert property (
        @(posedge mclk) disable iff (!rst_b)
        (sec_tick && !load && sec_q == rtcsa_pkg::SEC_MAX
         && min_q < rtcsa_pkg::MIN_MAX)
        |=> (sec_q == 6'h00 && min_q == $past(min_q) + 6'h01))
        else $error("seconds did not wrap into minutes");
endmodule

// ---- testbench/tb.sv ----
// Self-checking bench for the clock block top: APB tasks, table, calendar.
// Assumes shortened dividers: 200-cycle load tick, 4-cycle subsecond tick.
`timescale 1ns/1ps
module tb;
    typedef struct {logic w; logic [15:0] a; logic [31:0] d;
        logic [31:0] x; logic e;} rtcsa_row_t;
    typedef logic [7:0] rtcsa_tv_t [7];
    localparam logic [13:0] CTRL = rtcsa_pkg::IDX_CTRL;
    localparam int SLOW_CYC = 200;
    logic mclk = 1'b0;
    logic rst_b = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [15:0] paddr = 16'h0000;
    logic [31:0] pwdata = 32'h00000000;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic alarm_match;
    logic [6:0] osc_trim;
    logic [31:0] rd;
    logic er;
    logic [7:0] s;
    logic [13:0] fidx [7];
    int fail_count = 0;
    int cmp_count = 0;
    int cyc = 0;
    rtcsa_row_t rows [14] = '{
        '{0, 16'hA240, 32'h0, 32'h1, 0}, '{0, 16'h9410, 32'h0, 32'h40, 0},
        '{1, 16'h9410, 32'h15, 32'h0, 0}, '{0, 16'h9410, 32'h0, 32'h15, 0},
        '{1, 16'hA278, '1, 32'h0, 0}, '{0, 16'hA278, 32'h0, 32'h3F, 0},
        '{1, 16'hA27C, '1, 32'h0, 0}, '{0, 16'hA27C, 32'h0, 32'h1F, 0},
        '{1, 16'hA278, 32'h0, 32'h0, 0}, '{1, 16'hA27C, 32'h0, 32'h0, 0},
        '{0, 16'h0000, 32'h0, 32'h0, 1}, '{1, 16'h0000, 32'h7, 32'h0, 1},
        '{0, 16'hA242, 32'h0, 32'h0, 1}, '{0, 16'hA27C, 32'h0, 32'h0, 0}};

    rtcsa_top #(.SLOW_DIV(SLOW_CYC), .SUB_DIV(4)) dut_u (.mclk(mclk),
        .rst_b(rst_b), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .osc_trim(osc_trim),
        .alarm_match(alarm_match));

    // Clock
    always #5 mclk = ~mclk;

    // Hang guard
    always @(posedge mclk)
    begin
        cyc <= cyc + 1;
        if (cyc == 30000)
        begin
            fail_count = fail_count + 1;
            stop_test();
        end
    end

    // Verdict and end of run
    task automatic stop_test();
        $display("cmp_count=%0d fail_count=%0d", cmp_count, fail_count);
        if (fail_count == 0 && cmp_count > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask

    // Compare and count
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp)
        begin
            fail_count++;
            $display("mismatch at %0t got %h exp %h", $time, got, exp);
        end
    endtask

    // One APB transfer; read data and error taken at the pready edge
    task automatic apb(input logic w, input logic [15:0] a,
                       input logic [31:0] d);
        @(posedge mclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge mclk);
        penable <= 1'b1;
        do @(posedge mclk); while (pready !== 1'b1);
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic wrr(input logic [13:0] i, input logic [31:0] d);
        apb(1'b1, {i, 2'b00}, d);
    endtask

    task automatic rdr(input logic [13:0] i);
        apb(1'b0, {i, 2'b00}, 32'h0);
    endtask

    // Load a full time through the shadow and wait for the transfer
    task automatic set_time(input rtcsa_tv_t v);
        int n;
        wrr(CTRL, 32'h80);
        for (int k = 0; k < 7; k++)
            wrr(fidx[k], {24'h0, v[k]});
        // Keep the clear off the load tick so the first read still sees busy
        while (cyc % SLOW_CYC < 8)
            @(posedge mclk);
        wrr(CTRL, 32'h0);
        rdr(CTRL);
        chk(rd & 32'h80, 32'h80);
        n = 0;
        while (rd[7] !== 1'b0 && n < 80)
        begin
            rdr(CTRL);
            n++;
        end
        chk(rd & 32'h80, 32'h0);
    endtask

    // Read every time field and compare
    task automatic chk_time(input rtcsa_tv_t v);
        for (int k = 0; k < 7; k++)
        begin
            rdr(fidx[k]);
            chk(rd, {24'h0, v[k]});
        end
    endtask

    // Main sequence: reset, table, then hand-written cases
    initial
    begin
        fidx = '{rtcsa_pkg::IDX_SEC, rtcsa_pkg::IDX_MIN, rtcsa_pkg::IDX_HR,
            rtcsa_pkg::IDX_WDAY, rtcsa_pkg::IDX_DATE, rtcsa_pkg::IDX_MON,
            rtcsa_pkg::IDX_YEAR};
        repeat (4) @(posedge mclk);
        chk(32'(alarm_match), 32'h0);
        chk(32'(osc_trim), 32'h40);
        chk(prdata, 32'h00000000);
        chk(32'(pslverr), 32'h0);
        chk(32'(pready), 32'h1);
        rst_b <= 1'b1;
        foreach (rows[i])
        begin
            apb(rows[i].w, rows[i].a, rows[i].d);
            chk(32'(er), 32'(rows[i].e));
            if (!rows[i].w)
                chk(rd, rows[i].x);
        end
        chk(32'(osc_trim), 32'h15);
        set_time('{8'h3B, 8'h3B, 8'h17, 8'h07, 8'h1C, 8'h02, 8'h00});
        chk_time('{8'h3B, 8'h3B, 8'h17, 8'h07, 8'h1C, 8'h02, 8'h00});
        chk(32'(alarm_match), 32'h0);
        repeat (1100) @(posedge mclk);
        chk(32'(alarm_match), 32'h1);
        chk_time('{8'h00, 8'h00, 8'h00, 8'h01, 8'h1D, 8'h02, 8'h00});
        wrr(CTRL, 32'h40);
        rdr(CTRL);
        chk(rd & 32'h41, 32'h41);
        repeat (1100) @(posedge mclk);
        rdr(rtcsa_pkg::IDX_SEC);
        chk(rd, 32'h0);
        wrr(CTRL, 32'h0);
        rdr(CTRL);
        chk(rd & 32'h40, 32'h0);
        rdr(rtcsa_pkg::IDX_SEC);
        chk(rd, 32'h1);
        // Countdown: captures 40 cycles apart are 10 counts apart
        rdr(rtcsa_pkg::IDX_SUBSEC);
        s = rd[7:0];
        repeat (37) @(posedge mclk);
        rdr(rtcsa_pkg::IDX_SUBSEC);
        chk({24'h0, 8'(s - rd[7:0])}, 32'h0A);
        set_time('{8'h00, 8'h00, 8'h00, 8'h01, 8'h01, 8'h01, 8'hC8});
        repeat (1100) @(posedge mclk);
        rdr(CTRL);
        chk(rd & 32'h10, 32'h10);
        set_time('{8'h3B, 8'h3B, 8'h17, 8'h03, 8'h1C, 8'h02, 8'h01});
        wrr(CTRL, 32'h0);
        rdr(CTRL);
        chk(rd & 32'h10, 32'h0);
        repeat (1100) @(posedge mclk);
        chk_time('{8'h00, 8'h00, 8'h00, 8'h04, 8'h01, 8'h03, 8'h01});
        stop_test();
    end
endmodule
